// ---- design/rxgc_regs.svh ----
// Register offsets, field positions, reset values and counts for the gain monitor
`ifndef RXGC_REGS_SVH
`define RXGC_REGS_SVH
`define OFS_CTRL      8'h00
`define OFS_FE_THR    8'h04
`define OFS_ADC_THR   8'h08
`define OFS_LOWPWR    8'h0C
`define OFS_TIMING    8'h10
`define OFS_GAIN      8'h14
`define OFS_TBL       8'h18
`define OFS_STATUS    8'h1C
`define CTRL_MODE     0
`define CTRL_HALF     2
`define CTRL_HB       3
`define CTRL_DEC      6
`define CTRL_TAPS     8
`define THR_LARGE     0
`define THR_SMALL     8
`define ADC_COUNT     16
`define LP_THR        0
`define LP_INCR       16
`define TM_PKWAIT     0
`define TM_SETTLE     8
`define TM_DUR        16
`define GAIN_RX1      8
`define TBL_ADDR      16
`define TBL_RX        24
`define ST_IDX0       16
`define ST_IDX1       24
`define ST_TAPERR     10
`define RST_CTRL      32'h0000_8000
`define RST_FE_THR    32'h0000_1F2F
`define RST_ADC_THR   32'h0010_2030
`define RST_LOWPWR    32'h0010_0028
`define RST_TIMING    32'h0000_140A
`define TAPS_PER_CLK  8'h10
`define TAPS_MAX      8'h80
`define PWR_MIN_LOG2  5'h04
`define GAIN_IDX_MAX  7'h5A
`endif

// ---- design/rxgc_pkg.sv ----
// Types shared by both ends of the gain monitor link
package rxgc_pkg;
  typedef enum logic [1:0] {
    MANUAL_GAIN = 2'h0,
    FAST_ATTACK = 2'h1,
    SLOW_ATTACK = 2'h2
  } mode_type;
  typedef logic [6:0] gain_idx_type;
  typedef logic [15:0] gain_word_type;
endpackage

// ---- design/rxgc_if.sv ----
// Link between the receive monitor and the baseband processor
`timescale 1ns/1ps
interface rxgc_if;
  rxgc_pkg::mode_type      mode;
  logic                    fir_half;
  logic [2:0]              hb_log2;
  logic [1:0]              dec_log2;
  logic [7:0]              taps_req;
  logic [5:0]              fe_thr_l;
  logic [5:0]              fe_thr_s;
  logic [7:0]              adc_thr_l;
  logic [7:0]              adc_thr_s;
  logic [7:0]              adc_cnt;
  logic [6:0]              lp_thr;
  logic [15:0]             incr_time;
  logic [7:0]              pk_wait;
  logic [7:0]              settle;
  logic [3:0]              dur;
  rxgc_pkg::gain_idx_type  gain_idx [2];
  logic                    tbl_we;
  logic                    tbl_rx;
  logic [6:0]              tbl_addr;
  rxgc_pkg::gain_word_type tbl_data;
  logic [9:0]              ctrl_out;
  rxgc_pkg::gain_idx_type  idx_rb [2];
  logic                    tap_err;
  modport dev (
    input  mode, fir_half, hb_log2, dec_log2, taps_req, fe_thr_l, fe_thr_s,
    input  adc_thr_l, adc_thr_s, adc_cnt, lp_thr, incr_time, pk_wait, settle,
    input  dur, gain_idx, tbl_we, tbl_rx, tbl_addr, tbl_data,
    output ctrl_out, idx_rb, tap_err
  );
  modport bbp (
    output mode, fir_half, hb_log2, dec_log2, taps_req, fe_thr_l, fe_thr_s,
    output adc_thr_l, adc_thr_s, adc_cnt, lp_thr, incr_time, pk_wait, settle,
    output dur, gain_idx, tbl_we, tbl_rx, tbl_addr, tbl_data,
    input  ctrl_out, idx_rb, tap_err
  );
endinterface

// ---- design/settle_timer.sv ----
// Down counter that holds a busy level for a loaded number of cycles
`timescale 1ns/1ps
module settle_timer #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Start and length
  input  wire logic         start,
  input  wire logic [W-1:0] len,
  // Status
  output logic              busy
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign cnt_d = start ? len : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
  assign busy  = cnt_q != '0;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// ---- design/rx_monitor_dev.sv ----
// Receive gain monitor: detectors, power measurement, settling and gain table
// Functional notes
// - FIR clock is converter clock or half of it
// - FIR evaluates sixteen taps per FIR clock
// - Up to 128 taps once the clock ratio reaches eight; 16, 32 or 64 below that
// - Own gain table per receiver, pointer selects word
// - Automatic modes and one manual mode; manual follows processor
// - Power over sixteen samples minimum; peaks react fast
// - Two front-end thresholds, 16 mV times code+1
// - Controller clamps small threshold to at or below large
// - Manual mode routes overload flags to control pins
// - Converter samples are signed, clipped to -4..+4
// - Sum of squares over count, two shared thresholds
// - Low-power threshold in half-dB steps to -63.5
// - Fast attack: low power after increment time below
// - Manual: low power flags at once
// - Average power updates once per period per receiver, period shared
// - Duration is sixteen times two to field
// - Gain change resets detectors until peak wait ends, power until settled
// - Peak wait count before re-enabling overload detectors
// - Power taken at last half-band output, after settling
// - Automatic modes hold power reset twice settle value
// - Settling default twenty cycles, software scales it
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "rxgc_regs.svh"
module rx_monitor_dev (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    NRST,
  // Link to the baseband processor
  rxgc_if.dev                          LINK,
  // Converter samples per receiver
  input  wire logic [1:0]              ADC_VALID,
  input  wire logic signed [3:0]       ADC_SAMPLE [2],
  // Front-end peak level per receiver, in 16 mV units
  input  wire logic [6:0]              FE_LEVEL [2],
  // Last half-band output power, in 0.5 dB below full scale
  input  wire logic [1:0]              POWER_VALID,
  input  wire logic [6:0]              POWER_CODE [2],
  // Results
  output rxgc_pkg::gain_word_type      GAIN_WORD [2],
  output logic [6:0]                   AVG_POWER [2],
  output logic [1:0]                   POWER_UPDATE,
  output logic [7:0]                   TAPS_AVAIL,
  output logic                         TAP_ERR,
  output logic                         FIR_CLK_HALF
);
  rxgc_pkg::gain_word_type tbl [2][128];
  rxgc_pkg::gain_idx_type  idx_q [2];
  logic [4:0]              co_q [2];
  wire                     manual = LINK.mode == rxgc_pkg::MANUAL_GAIN;

  // Tap budget: 16 taps per FIR clock times clock ratio, capped at 128
  wire [3:0] ratio_sum = {1'b0, LINK.hb_log2} + {2'b00, LINK.dec_log2};
  wire [3:0] ratio_log2 = (ratio_sum > {3'h0, LINK.fir_half}) ?
                          ratio_sum - {3'h0, LINK.fir_half} : 4'h0;
  wire [7:0] taps_d = (ratio_log2 >= 4'h3) ? `TAPS_MAX :
                      8'(`TAPS_PER_CLK << ratio_log2);
  wire       tap_err_d = (LINK.taps_req == 8'h00) || (LINK.taps_req[3:0] != 4'h0) ||
                         (LINK.taps_req > taps_d);

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      TAPS_AVAIL   <= 8'h00;
      TAP_ERR      <= 1'b0;
      FIR_CLK_HALF <= 1'b0;
    end
    else
    begin
      TAPS_AVAIL   <= taps_d;
      TAP_ERR      <= tap_err_d;
      FIR_CLK_HALF <= LINK.fir_half;
    end
  end

  // Table contents are not reset; software loads them before use
  always_ff @(posedge CLK)
  begin
    if (LINK.tbl_we)
      tbl[LINK.tbl_rx][LINK.tbl_addr] <= LINK.tbl_data;
  end

  assign LINK.ctrl_out = {co_q[1], co_q[0]};
  assign LINK.idx_rb   = idx_q;
  assign LINK.tap_err  = TAP_ERR;

  for (genvar r = 0; r < 2; r++)
  begin : g_rx
    logic        pk_busy;
    logic        st_busy;
    logic        fe_l_q;
    logic        fe_s_q;
    logic        adc_l_q;
    logic        adc_s_q;
    logic        lp_q;
    logic        below_q;
    logic [7:0]  adc_n_q;
    logic [11:0] ssq_q;
    logic [19:0] pw_n_q;
    logic [26:0] acc_q;
    logic [15:0] lo_cnt_q;

    // Gain pointer: processor in manual mode, own stepping otherwise
    wire         quiet = !pk_busy && !st_busy;
    wire [6:0]   auto_nxt = ((fe_l_q || adc_l_q) && idx_q[r] != 7'h00) ? idx_q[r] - 7'h01 :
                            (lp_q && idx_q[r] != `GAIN_IDX_MAX) ? idx_q[r] + 7'h01 :
                            idx_q[r];
    wire [6:0]   idx_d = manual ? LINK.gain_idx[r] : quiet ? auto_nxt : idx_q[r];
    wire         chg = idx_d != idx_q[r];
    wire         det_en = !pk_busy && !chg;
    wire         pw_en = !st_busy && !chg;
    // Automatic modes hold power reset twice as long as manual mode
    wire [8:0]   hold_len = manual ? {1'b0, LINK.settle} : {LINK.settle, 1'b0};

    settle_timer #(.W(8)) u_peak_wait (
      .clk   (CLK),
      .nrst  (NRST),
      .start (chg),
      .len   (LINK.pk_wait),
      .busy  (pk_busy)
    );

    settle_timer #(.W(9)) u_power_hold (
      .clk   (CLK),
      .nrst  (NRST),
      .start (chg),
      .len   (hold_len),
      .busy  (st_busy)
    );

    // Converter sample clipped to +-4, squared
    wire signed [3:0] clip = (ADC_SAMPLE[r] > 4'sd4) ? 4'sd4 :
                             (ADC_SAMPLE[r] < -4'sd4) ? -4'sd4 : ADC_SAMPLE[r];
    wire [3:0]   mag = clip[3] ? 4'(-clip) : 4'(clip);
    // Square at full width; a 4-bit product would lose the 16 of a clipped sample
    wire [7:0]   sq = {4'h0, mag} * {4'h0, mag};
    wire [11:0]  z = ssq_q + {4'h0, sq};
    wire         adc_end = adc_n_q + 8'h01 >= LINK.adc_cnt;

    // Measurement length 16 * 2^dur samples
    wire [19:0]  pw_len = 20'h00010 << LINK.dur;
    wire         pw_end = pw_n_q == pw_len - 20'h00001;
    wire [26:0]  acc_sum = acc_q + {20'h00000, POWER_CODE[r]};
    wire [4:0]   shift = `PWR_MIN_LOG2 + {1'b0, LINK.dur};
    wire [26:0]  avg_full = acc_sum >> shift;
    wire         below_d = avg_full[6:0] > LINK.lp_thr;

    always_ff @(posedge CLK)
    begin
      if (!NRST)
        idx_q[r] <= 7'h00;
      else
        idx_q[r] <= idx_d;
    end

    always_ff @(posedge CLK)
    begin
      if (!NRST)
        GAIN_WORD[r] <= 16'h0000;
      else
        GAIN_WORD[r] <= tbl[r][idx_q[r]];
    end

    // Peak flags follow the level directly while enabled
    always_ff @(posedge CLK)
    begin
      if (!NRST || !det_en)
      begin
        fe_l_q <= 1'b0;
        fe_s_q <= 1'b0;
      end
      else
      begin
        fe_l_q <= FE_LEVEL[r] > {1'b0, LINK.fe_thr_l} + 7'h01;
        fe_s_q <= FE_LEVEL[r] > {1'b0, LINK.fe_thr_s} + 7'h01;
      end
    end

    always_ff @(posedge CLK)
    begin
      if (!NRST || !det_en)
      begin
        adc_n_q <= 8'h00;
        ssq_q   <= 12'h000;
        adc_l_q <= 1'b0;
        adc_s_q <= 1'b0;
      end
      else if (ADC_VALID[r] && adc_end)
      begin
        adc_n_q <= 8'h00;
        ssq_q   <= 12'h000;
        adc_l_q <= z > {4'h0, LINK.adc_thr_l};
        adc_s_q <= z > {4'h0, LINK.adc_thr_s};
      end
      else if (ADC_VALID[r])
      begin
        adc_n_q <= adc_n_q + 8'h01;
        ssq_q   <= z;
      end
    end

    // Average keeps its last value through a hold; accumulation restarts and the below flag clears
    always_ff @(posedge CLK)
    begin
      if (!NRST)
      begin
        pw_n_q          <= 20'h00000;
        acc_q           <= 27'h0000000;
        AVG_POWER[r]    <= 7'h00;
        POWER_UPDATE[r] <= 1'b0;
        below_q         <= 1'b0;
      end
      else if (!pw_en)
      begin
        pw_n_q          <= 20'h00000;
        acc_q           <= 27'h0000000;
        POWER_UPDATE[r] <= 1'b0;
        below_q         <= 1'b0;
      end
      else if (POWER_VALID[r] && pw_end)
      begin
        pw_n_q          <= 20'h00000;
        acc_q           <= 27'h0000000;
        AVG_POWER[r]    <= avg_full[6:0];
        POWER_UPDATE[r] <= 1'b1;
        below_q         <= below_d;
      end
      else
      begin
        POWER_UPDATE[r] <= 1'b0;
        if (POWER_VALID[r])
        begin
          pw_n_q <= pw_n_q + 20'h00001;
          acc_q  <= acc_sum;
        end
      end
    end

    // Cycles spent below threshold, saturating
    always_ff @(posedge CLK)
    begin
      if (!NRST || !pw_en || !below_q)
        lo_cnt_q <= 16'h0000;
      else if (lo_cnt_q != 16'hFFFF)
        lo_cnt_q <= lo_cnt_q + 16'h0001;
    end

    always_ff @(posedge CLK)
    begin
      if (!NRST || !pw_en)
        lp_q <= 1'b0;
      else if (manual)
        lp_q <= below_q;
      else
        lp_q <= below_q && (lo_cnt_q >= LINK.incr_time);
    end

    always_ff @(posedge CLK)
    begin
      if (!NRST || !manual)
        co_q[r] <= 5'h00;
      else
        co_q[r] <= {lp_q, adc_s_q, adc_l_q, fe_s_q, fe_l_q};
    end
  end
endmodule

// ---- design/bbp_ctrl.sv ----
// Baseband-side controller: AHB-Lite registers that steer the monitor link
`timescale 1ns/1ps
`include "rxgc_regs.svh"
module bbp_ctrl (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Link to the receive monitor
  rxgc_if.bbp              LINK
);
  logic [31:0] ctrl_q;
  logic [31:0] fe_q;
  logic [31:0] adc_q;
  logic [31:0] lp_q;
  logic [31:0] tm_q;
  logic [31:0] gain_q;
  logic [31:0] tbl_q;
  logic        tbl_we_q;
  logic        wr_q;
  logic [7:0]  wa_q;
  logic [31:0] st_q;

  // Word transfers only; HSIZE is not checked
  wire        take = HSEL && HREADY && HTRANS[1];
  wire [7:0]  ra = HADDR[7:0];
  wire [31:0] rd = (ra == `OFS_CTRL)    ? ctrl_q :
                   (ra == `OFS_FE_THR)  ? fe_q   :
                   (ra == `OFS_ADC_THR) ? adc_q  :
                   (ra == `OFS_LOWPWR)  ? lp_q   :
                   (ra == `OFS_TIMING)  ? tm_q   :
                   (ra == `OFS_GAIN)    ? gain_q :
                   (ra == `OFS_TBL)     ? tbl_q  :
                   (ra == `OFS_STATUS)  ? st_q   : 32'h0000_0000;
  wire        wr = wr_q;

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      wr_q      <= 1'b0;
      wa_q      <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      wr_q      <= take && HWRITE;
      wa_q      <= ra;
      HRDATA    <= (take && !HWRITE) ? rd : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      ctrl_q   <= `RST_CTRL;
      fe_q     <= `RST_FE_THR;
      adc_q    <= `RST_ADC_THR;
      lp_q     <= `RST_LOWPWR;
      tm_q     <= `RST_TIMING;
      gain_q   <= 32'h0000_0000;
      tbl_q    <= 32'h0000_0000;
      tbl_we_q <= 1'b0;
    end
    else
    begin
      if (wr && wa_q == `OFS_CTRL)
        ctrl_q <= HWDATA;
      if (wr && wa_q == `OFS_FE_THR)
        fe_q <= HWDATA;
      if (wr && wa_q == `OFS_ADC_THR)
        adc_q <= HWDATA;
      if (wr && wa_q == `OFS_LOWPWR)
        lp_q <= HWDATA;
      if (wr && wa_q == `OFS_TIMING)
        tm_q <= HWDATA;
      if (wr && wa_q == `OFS_GAIN)
        gain_q <= HWDATA;
      if (wr && wa_q == `OFS_TBL)
        tbl_q <= HWDATA;
      tbl_we_q <= wr && wa_q == `OFS_TBL;
    end
  end

  // Flags sampled from the control pins in manual mode
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      st_q <= 32'h0000_0000;
    else
    begin
      st_q <= 32'h0000_0000;
      st_q[9:0] <= LINK.ctrl_out;
      st_q[`ST_TAPERR] <= LINK.tap_err;
      st_q[`ST_IDX0 +: 7] <= LINK.idx_rb[0];
      st_q[`ST_IDX1 +: 7] <= LINK.idx_rb[1];
    end
  end

  wire [5:0] fe_l = fe_q[`THR_LARGE +: 6];
  wire [5:0] fe_s = fe_q[`THR_SMALL +: 6];

  assign LINK.mode        = rxgc_pkg::mode_type'(ctrl_q[`CTRL_MODE +: 2]);
  assign LINK.fir_half    = ctrl_q[`CTRL_HALF];
  assign LINK.hb_log2     = ctrl_q[`CTRL_HB +: 3];
  assign LINK.dec_log2    = ctrl_q[`CTRL_DEC +: 2];
  assign LINK.taps_req    = ctrl_q[`CTRL_TAPS +: 8];
  assign LINK.fe_thr_l    = fe_l;
  // Small threshold never above the large one
  assign LINK.fe_thr_s    = (fe_s > fe_l) ? fe_l : fe_s;
  assign LINK.adc_thr_l   = adc_q[`THR_LARGE +: 8];
  assign LINK.adc_thr_s   = adc_q[`THR_SMALL +: 8];
  assign LINK.adc_cnt     = adc_q[`ADC_COUNT +: 8];
  assign LINK.lp_thr      = lp_q[`LP_THR +: 7];
  assign LINK.incr_time   = lp_q[`LP_INCR +: 16];
  assign LINK.pk_wait     = tm_q[`TM_PKWAIT +: 8];
  assign LINK.settle      = tm_q[`TM_SETTLE +: 8];
  assign LINK.dur         = tm_q[`TM_DUR +: 4];
  assign LINK.gain_idx[0] = gain_q[6:0];
  assign LINK.gain_idx[1] = gain_q[`GAIN_RX1 +: 7];
  assign LINK.tbl_we      = tbl_we_q;
  assign LINK.tbl_rx      = tbl_q[`TBL_RX];
  assign LINK.tbl_addr    = tbl_q[`TBL_ADDR +: 7];
  assign LINK.tbl_data    = tbl_q[15:0];
endmodule

// ---- dv/rxgc_props.sv ----
// Checker for the monitor link: flags, pointer and tap budget
`timescale 1ns/1ps
`include "rxgc_regs.svh"
module rxgc_props (
  // Clock and reset
  input wire logic              CLK,
  input wire logic              NRST,
  // Link signals
  input rxgc_pkg::mode_type     mode,
  input rxgc_pkg::gain_idx_type gain_idx [2],
  input wire logic [7:0]        pk_wait,
  input wire logic [7:0]        taps_req,
  input wire logic [9:0]        ctrl_out,
  input rxgc_pkg::gain_idx_type idx_rb [2],
  input wire logic              tap_err
);
  logic [6:0] prev_q;
  logic [7:0] since_q;
  wire        manual = (mode == rxgc_pkg::MANUAL_GAIN);
  wire        bad_taps = (taps_req == 8'h00) || (taps_req[3:0] != 4'h0) || (taps_req > 8'h80);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Saturates so a long quiet stretch never looks like a fresh write
  always_ff @(posedge CLK)
  begin
    prev_q <= gain_idx[0];
    if (!NRST)
      since_q <= 8'hFF;
    else if (gain_idx[0] != prev_q)
      since_q <= 8'h00;
    else if (since_q != 8'hFF)
      since_q <= since_q + 8'h01;
  end
  chk_auto_pins_quiet: assert property (
    (!manual) [*3] |-> ctrl_out == 10'h000)
    else $error("control pins active outside manual mode");
  chk_manual_idx_follow: assert property (
    manual && $past(manual) && $changed(gain_idx[0]) |=> idx_rb[0] == $past(gain_idx[0]))
    else $error("pointer did not follow manual write");
  chk_idx_in_range: assert property (
    idx_rb[0] <= `GAIN_IDX_MAX && idx_rb[1] <= `GAIN_IDX_MAX)
    else $error("gain pointer beyond table");
  chk_tap_count_err: assert property (
    bad_taps [*3] |-> tap_err)
    else $error("illegal tap count not flagged");
  chk_peak_wait_quiet: assert property (
    manual && since_q >= 8'h02 && (9'(since_q) + 9'h002 < 9'(pk_wait)) |-> ctrl_out[3:0] == 4'h0)
    else $error("overload flag during peak wait");
  chk_fe_large_small: assert property (
    manual |-> (!ctrl_out[0] || ctrl_out[1]) && (!ctrl_out[5] || ctrl_out[6]))
    else $error("large overload without small overload");
  chk_auto_idx_step: assert property (
    !manual && $past(!manual) |-> 7'(idx_rb[0] - $past(idx_rb[0]) + 7'h01) <= 7'h02)
    else $error("automatic pointer jumped");
  chk_auto_hold_gap: assert property (
    !manual && $changed(idx_rb[0]) |=> $stable(idx_rb[0]) [*8])
    else $error("pointer moved during settling hold");
  cov_manual_write: cover property (manual && $changed(gain_idx[0]));
  cov_auto_step: cover property (!manual && $changed(idx_rb[0]));
  cov_tap_err: cover property ($rose(tap_err));
endmodule

// ---- dv/tb_rx_gain_detect_monitor.sv ----
// Testbench joining the baseband controller and the receive monitor
`timescale 1ns/1ps
`include "rxgc_regs.svh"
module tb_rx_gain_detect_monitor;
  logic                    clk = 1'b0;
  logic                    nrst = 1'b0;
  logic                    hsel = 1'b0;
  logic [31:0]             haddr = 32'h0;
  logic [1:0]              htrans = 2'h0;
  logic                    hwrite = 1'b0;
  logic [31:0]             hwdata = 32'h0;
  logic [31:0]             hrdata;
  logic                    hready;
  logic                    hresp;
  logic [1:0]              adc_v = 2'h0;
  logic signed [3:0]       adc_s [2] = '{4'sh0, 4'sh0};
  logic [6:0]              fe_lvl [2] = '{7'h00, 7'h00};
  logic [1:0]              pwr_v = 2'h0;
  logic [6:0]              pwr_c [2] = '{7'h00, 7'h00};
  rxgc_pkg::gain_word_type gword [2];
  logic [6:0]              avg [2];
  logic [1:0]              pupd;
  logic [7:0]              taps;
  logic                    terr;
  logic                    half;
  logic [31:0]             rd;
  int                      fails = 0;
  int                      checks_done = 0;
  rxgc_if lnk ();
  bbp_ctrl bbp_ctrl_i (.CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .LINK(lnk));
  rx_monitor_dev rx_monitor_dev_i (.CLK(clk), .NRST(nrst), .LINK(lnk), .ADC_VALID(adc_v),
    .ADC_SAMPLE(adc_s), .FE_LEVEL(fe_lvl), .POWER_VALID(pwr_v), .POWER_CODE(pwr_c),
    .GAIN_WORD(gword), .AVG_POWER(avg), .POWER_UPDATE(pupd), .TAPS_AVAIL(taps),
    .TAP_ERR(terr), .FIR_CLK_HALF(half));
  rxgc_props rxgc_props_i (.CLK(clk), .NRST(nrst), .mode(lnk.mode), .gain_idx(lnk.gain_idx),
    .pk_wait(lnk.pk_wait), .taps_req(lnk.taps_req), .ctrl_out(lnk.ctrl_out),
    .idx_rb(lnk.idx_rb), .tap_err(lnk.tap_err));
  always #20 clk = ~clk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Single word transfer; the wait loops rely on the watchdog
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // Edges between two update pulses of receiver 0
  task automatic gap(output int n);
    n = 1;
    while (pupd[0] !== 1'b1) @(posedge clk);
    @(posedge clk);
    while (pupd[0] !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_regs();
    rdchk("ctrl", `OFS_CTRL, `RST_CTRL);
    rdchk("fe_thr", `OFS_FE_THR, `RST_FE_THR);
    rdchk("adc_thr", `OFS_ADC_THR, `RST_ADC_THR);
    rdchk("lowpwr", `OFS_LOWPWR, `RST_LOWPWR);
    xfer(1'b0, `OFS_TIMING, 32'h0);
    chk("settle", 32'h14, {24'h0, rd[15:8]});
    wr(8'h24, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h24, 32'h0);
  endtask
  task automatic t_taps();
    logic [15:0] cw [6] = '{16'h8058, 16'h304C, 16'h2014, 16'h0090, 16'h1898, 16'h4048};
    int          r;
    int          av;
    foreach (cw[i])
    begin
      wr(`OFS_CTRL, {16'h0, cw[i]});
      cyc(3);
      r = int'(cw[i][5:3]) + int'(cw[i][7:6]) - int'(cw[i][2]);
      av = (r >= 3) ? 128 : (16 << r);
      chk("taps_avail", 32'(av), {24'h0, taps});
      chk("tap_err", 32'(cw[i][15:8] == 0 || cw[i][11:8] != 0 || cw[i][15:8] > av),
        {31'h0, terr});
      chk("fir_half", {31'h0, cw[i][2]}, {31'h0, half});
    end
    wr(`OFS_CTRL, 32'h0000_8000);
  endtask
  task automatic t_table();
    wr(`OFS_TBL, 32'h0005_A5C3);
    wr(`OFS_TBL, 32'h0105_5A3C);
    wr(`OFS_TBL, 32'h0006_1234);
    wr(`OFS_GAIN, 32'h0000_0505);
    cyc(3);
    chk("word_rx0", 32'h0000_A5C3, {16'h0, gword[0]});
    chk("word_rx1", 32'h0000_5A3C, {16'h0, gword[1]});
    wr(`OFS_GAIN, 32'h0000_0506);
    cyc(3);
    chk("word_next", 32'h0000_1234, {16'h0, gword[0]});
    xfer(1'b0, `OFS_STATUS, 32'h0);
    chk("idx0", 32'h6, {25'h0, rd[22:16]});
    chk("idx1", 32'h5, {25'h0, rd[30:24]});
    chk("tap_err_st", 32'h1, {31'h0, rd[10]});
  endtask
  task automatic t_fe();
    logic [6:0] lv [4] = '{7'h06, 7'h07, 7'h0B, 7'h0C};
    cyc(12);
    wr(`OFS_FE_THR, 32'h0000_050A);
    foreach (lv[i])
    begin
      fe_lvl <= '{lv[i], lv[i]};
      cyc(3);
      chk("fe_rx0", {30'h0, lv[i] > 7'h06, lv[i] > 7'h0B}, 32'(lnk.ctrl_out[1:0]));
      chk("fe_rx1", {30'h0, lv[i] > 7'h06, lv[i] > 7'h0B}, 32'(lnk.ctrl_out[6:5]));
    end
    wr(`OFS_FE_THR, 32'h0000_140A);
    fe_lvl <= '{7'h0C, 7'h0C};
    cyc(3);
    chk("fe_clamp", 32'h3, 32'(lnk.ctrl_out[1:0]));
    rdchk("fe_thr_rb", `OFS_FE_THR, 32'h0000_140A);
    fe_lvl <= '{7'h0C, 7'h0C};
    wr(`OFS_CTRL, 32'h0000_8001);
    // Long enough for the peak wait after the automatic step to pass
    cyc(12);
    chk("pins_auto", 32'h0, 32'(lnk.ctrl_out));
    wr(`OFS_CTRL, 32'h0000_8000);
    fe_lvl <= '{7'h00, 7'h00};
  endtask
  task automatic t_adc();
    logic signed [3:0] sv [4] = '{-4'sh7, 4'sh2, 4'sh3, 4'sh5};
    int                a;
    wr(`OFS_ADC_THR, 32'h0004_1428);
    adc_v <= 2'h3;
    foreach (sv[i])
    begin
      adc_s <= '{sv[i], sv[i]};
      a = (sv[i] < 0) ? -sv[i] : sv[i];
      a = (a > 4) ? 4 : a;
      cyc(16);
      chk("adc_rx0", {30'h0, 4 * a * a > 20, 4 * a * a > 40}, 32'(lnk.ctrl_out[3:2]));
      chk("adc_rx1", {30'h0, 4 * a * a > 20, 4 * a * a > 40}, 32'(lnk.ctrl_out[8:7]));
    end
    adc_v <= 2'h0;
  endtask
  task automatic t_pwr();
    int n;
    pwr_v <= 2'h3;
    pwr_c <= '{7'h32, 7'h32};
    gap(n);
    gap(n);
    chk("period16", 32'h10, 32'(n));
    chk("avg50", 32'h32, {25'h0, avg[0]});
    cyc(3);
    chk("low_on", 32'h1, {31'h0, lnk.ctrl_out[4]});
    pwr_c <= '{7'h1E, 7'h1E};
    wr(`OFS_TIMING, 32'h0001_140A);
    gap(n);
    gap(n);
    chk("period32", 32'h20, 32'(n));
    chk("avg30", 32'h1E, {25'h0, avg[1]});
    cyc(3);
    chk("low_off", 32'h0, {31'h0, lnk.ctrl_out[9]});
  endtask
  task automatic t_auto();
    int         n;
    logic [6:0] p;
    wr(`OFS_GAIN, 32'h0000_0028);
    cyc(12);
    fe_lvl <= '{7'h14, 7'h00};
    wr(`OFS_CTRL, 32'h0000_8001);
    p = lnk.idx_rb[0];
    while (lnk.idx_rb[0] === p) @(posedge clk);
    p = lnk.idx_rb[0];
    n = 0;
    while (lnk.idx_rb[0] === p)
    begin
      @(posedge clk);
      n++;
    end
    chk("step", {25'h0, p - 7'h01}, {25'h0, lnk.idx_rb[0]});
    chk("hold", 32'h1, 32'(n >= 2 * 20));
    cyc(10);
    wr(`OFS_CTRL, 32'h0000_8000);
    fe_lvl <= '{7'h00, 7'h00};
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    cyc(2);
    t_regs();
    t_taps();
    t_table();
    t_fe();
    t_adc();
    t_pwr();
    t_auto();
    wrap_up();
  end
endmodule
